// File: design/cpa_pkg.sv
// Constants shared by the compare and PWM channel array
`default_nettype none
package cpa_pkg;
  localparam int CPA_CHANNELS = 4;
  localparam int CPA_TB_WIDTH = 16;
  // Register byte offsets
  localparam logic [7:0] CPA_CTRL_BASE_OFS = 8'h00;
  localparam logic [7:0] CPA_VALUE_BASE_OFS = 8'h10;
  localparam logic [7:0] CPA_FLAG_OFS = 8'h20;
  localparam logic [7:0] CPA_CONFIG_OFS = 8'h24;
  localparam logic [7:0] CPA_STATUS_OFS = 8'h28;
  // Control register fields
  localparam int CPA_SEL_POS = 0;
  localparam int CPA_CLR_POS = 1;
  localparam int CPA_ACT_POS = 2;
  localparam int CPA_ACT_WIDTH = 3;
  localparam int CPA_CTRL_WIDTH = 5;
  // Config register fields
  localparam int CPA_CONV_EN_POS = 0;
  localparam int CPA_EXT_BUS_POS = 1;
  // Status register fields
  localparam int CPA_STAT_PIN_POS = 0;
  localparam int CPA_STAT_PWM_POS = 4;
  // Match action codes
  localparam logic [2:0] CPA_ACT_NONE = 3'h0;
  localparam logic [2:0] CPA_ACT_SET = 3'h1;
  localparam logic [2:0] CPA_ACT_CLEAR = 3'h2;
  localparam logic [2:0] CPA_ACT_TOGGLE = 3'h3;
  localparam logic [1:0] CPA_ACT_PWM_HI = 2'h2;
  // Reset values
  localparam logic [4:0] CPA_CTRL_RESET = 5'h00;
  localparam logic [15:0] CPA_VALUE_RESET = 16'h0000;
  localparam logic [15:0] CPA_TOP_RESET = 16'hffff;
  localparam logic CPA_PIN_RESET = 1'b1;
  // Bus responses
  localparam logic [1:0] CPA_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPA_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: design/cpa_channel.sv
// One compare channel: match detection, pin action and PWM buffering
`default_nettype none
module cpa_channel
  import cpa_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Channel control
  input wire logic compare_select_bit,
  input wire logic clear_on_match_bit,
  input wire logic [2:0] match_action_field,
  input wire logic [15:0] value_buf,
  // Timebase view
  input wire logic [15:0] timebase_count,
  input wire logic timebase_step,
  input wire logic timebase_wrap,
  input wire logic counting_down,
  input wire logic center_mode,
  input wire logic [15:0] top_active,
  // Results
  output logic match_event,
  output logic clear_request,
  output logic pwm_active,
  output logic pin_state
);
  logic [15:0] cmp_reg;
  logic [15:0] cmp_next;
  logic pin_reg;
  logic pin_next;
  logic polarity;
  logic pwm_edge;
  logic [15:0] wrap_cmp;

  // Match decode, once per counter step
  assign pwm_active = compare_select_bit && (match_action_field[2:1] == CPA_ACT_PWM_HI);
  assign match_event = compare_select_bit && timebase_step
    && (timebase_count == cmp_reg);
  assign clear_request = match_event && clear_on_match_bit;
  assign polarity = match_action_field[0];
  assign pwm_edge = match_event && (cmp_reg < top_active) && (cmp_reg != 16'h0000);
  assign wrap_cmp = value_buf;

  // Active compare value: buffered in PWM, direct otherwise
  assign cmp_next = (!pwm_active || timebase_wrap) ? value_buf : cmp_reg;

  // Pin action selection
  always_comb
  begin
    pin_next = pin_reg;
    if (pwm_active && timebase_wrap && !center_mode)
    begin
      pin_next = (wrap_cmp == 16'h0000) ? polarity : ~polarity;
    end
    else if (pwm_active && pwm_edge)
    begin
      if (center_mode)
        pin_next = counting_down ? polarity : ~polarity;
      else
        pin_next = polarity;
    end
    else if (!pwm_active && match_event)
    begin
      unique case (match_action_field)
        CPA_ACT_SET: pin_next = 1'b1;
        CPA_ACT_CLEAR: pin_next = 1'b0;
        CPA_ACT_TOGGLE: pin_next = ~pin_reg;
        default: pin_next = pin_reg;
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmp_reg <= CPA_VALUE_RESET;
      pin_reg <= CPA_PIN_RESET;
    end
    else
    begin
      cmp_reg <= cmp_next;
      pin_reg <= pin_next;
    end
  end

  assign pin_state = pin_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Checks on the channel
  step_once_a: assert property (!timebase_step |-> !match_event)
    else $error("match raised without a counter step");
  set_action_a: assert property (match_event && !pwm_active
    && match_action_field == CPA_ACT_SET |=> pin_state)
    else $error("set action did not raise the pin");
  toggle_action_a: assert property (match_event && !pwm_active
    && match_action_field == CPA_ACT_TOGGLE |=> pin_state != $past(pin_state))
    else $error("toggle action did not invert the pin");
  pwm_buffer_a: assert property (pwm_active && !timebase_wrap
    && $past(pwm_active) |=> $stable(cmp_reg))
    else $error("pwm compare value changed between wraps");
  pwm_zero_a: assert property (pwm_active && !center_mode && timebase_wrap
    && value_buf == 16'h0000 |=> pin_state == polarity)
    else $error("zero compare value did not hold the active level");
  pwm_cover_c: cover property (pwm_active && timebase_wrap ##[1:20] pwm_edge);
endmodule
`default_nettype wire

// File: design/cpa_top.sv
// Compare and PWM channel array with AXI4-Lite register access
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
// Overview of operation
// - With compare select set, counter equal to channel value raises a compare event.
// - Every compare event sets the channel match flag in the flag register.
// - With clear-on-match set, a compare event clears the timebase to zero.
// - The match action field sets, clears or toggles the channel pin.
// - Codes: 000 flag only, 001 high, 010 low, 011 invert, 11x reserved.
// - Pin actions happen whether or not the interrupt is enabled.
// - Reset sets every channel output state to one.
// - C and D idle with converter on; all idle on external bus.
// - Works in every timebase mode; actions only for values within range.
// - Clear-on-match restarts the timebase, so value sets the event interval.
// - In up/down count modes matches act on both slopes.
// - Compare select with action 10x gives PWM with buffered compare value.
// - In PWM, code 100 is inverting and 101 non-inverting.
// - PWM resolution spans 2 to 16 bits, set by TOP.
// - Edge-aligned PWM counts zero to TOP then restarts; period TOP plus one.
// - Non-inverting edge PWM: high on match, low at restart.
// - Inverting edge PWM: low on match, high at restart.
// - TOP takes effect only at the TOP-to-zero wrap.
// - In PWM, compare value loads from its buffer only at the wrap.
// - Value at or above TOP holds low non-inverting, high inverting; done in edge mode only, up/down modes leave the pin unchanged.
// - Value zero holds high non-inverting, low inverting; done in edge mode only, up/down modes leave the pin unchanged.
module cpa_top
  import cpa_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timebase interface
  input wire logic [15:0] timebase_count,
  input wire logic timebase_step,
  input wire logic timebase_wrap,
  input wire logic timebase_counting_down,
  input wire logic [15:0] top_value,
  input wire logic [1:0] count_mode_field,
  output logic timebase_clear,
  // Output pins
  output logic [CPA_CHANNELS-1:0] channel_output_pin,
  output logic [CPA_CHANNELS-1:0] channel_output_enable
);
  localparam int NCH = CPA_CHANNELS;

  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32)
  begin : g_bad_addr
    $error("ADDR_WIDTH must be between 8 and 32");
  end

  // Bus state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Register state
  logic [CPA_CTRL_WIDTH-1:0] ctrl_reg [NCH];
  logic [15:0] value_reg [NCH];
  logic [NCH-1:0] flag_reg;
  logic [NCH-1:0] flag_next;
  logic [1:0] config_reg;
  logic [15:0] top_active_reg;
  logic timebase_clear_reg;
  logic [NCH-1:0] pin_out_reg;
  logic [NCH-1:0] pin_en_reg;

  // Channel results
  logic [NCH-1:0] match_evt;
  logic [NCH-1:0] clear_req;
  logic [NCH-1:0] pwm_on;
  logic [NCH-1:0] pin_state;
  logic [NCH-1:0] pin_block;

  // Handshake decode
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic b_done;
  logic r_done;
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign b_done = bvalid_reg && s_axi_bready;
  assign r_done = rvalid_reg && s_axi_rready;

  // Write address decode
  logic [7:0] wr_ofs;
  logic wr_high_zero;
  logic wr_ctrl;
  logic wr_value;
  logic wr_flag;
  logic wr_config;
  logic wr_status;
  logic wr_ok;
  logic [1:0] wr_ch;
  assign wr_ofs = {awaddr_reg[7:2], 2'h0};
  assign wr_high_zero = (ADDR_WIDTH == 8) ? 1'b1 : (awaddr_reg >> 8) == '0;
  assign wr_ch = awaddr_reg[3:2];
  assign wr_ctrl = wr_high_zero && (wr_ofs[7:4] == CPA_CTRL_BASE_OFS[7:4]);
  assign wr_value = wr_high_zero && (wr_ofs[7:4] == CPA_VALUE_BASE_OFS[7:4]);
  assign wr_flag = wr_high_zero && (wr_ofs == CPA_FLAG_OFS);
  assign wr_config = wr_high_zero && (wr_ofs == CPA_CONFIG_OFS);
  assign wr_status = wr_high_zero && (wr_ofs == CPA_STATUS_OFS);
  assign wr_ok = wr_ctrl || wr_value || wr_flag || wr_config || wr_status;

  // Read address decode
  logic [7:0] rd_ofs;
  logic rd_high_zero;
  logic [1:0] rd_ch;
  logic rd_ctrl;
  logic rd_value;
  logic rd_ok;
  logic [31:0] rd_word;
  logic [31:0] rd_ctrl_word;
  logic [31:0] rd_value_word;
  logic [31:0] rd_status_word;
  assign rd_ofs = {s_axi_araddr[7:2], 2'h0};
  assign rd_high_zero = (ADDR_WIDTH == 8) ? 1'b1 : (s_axi_araddr >> 8) == '0;
  assign rd_ch = s_axi_araddr[3:2];
  assign rd_ctrl = rd_high_zero && (rd_ofs[7:4] == CPA_CTRL_BASE_OFS[7:4]);
  assign rd_value = rd_high_zero && (rd_ofs[7:4] == CPA_VALUE_BASE_OFS[7:4]);
  assign rd_ctrl_word = {27'h0, ctrl_reg[rd_ch]};
  assign rd_value_word = {16'h0, value_reg[rd_ch]};
  assign rd_status_word = {24'h0, pwm_on, pin_out_reg};
  assign rd_ok = rd_ctrl || rd_value || (rd_high_zero
    && (rd_ofs == CPA_FLAG_OFS || rd_ofs == CPA_CONFIG_OFS || rd_ofs == CPA_STATUS_OFS));
  assign rd_word = rd_ctrl ? rd_ctrl_word
    : rd_value ? rd_value_word
    : (rd_high_zero && rd_ofs == CPA_FLAG_OFS) ? {28'h0, flag_reg}
    : (rd_high_zero && rd_ofs == CPA_CONFIG_OFS) ? {30'h0, config_reg}
    : (rd_high_zero && rd_ofs == CPA_STATUS_OFS) ? rd_status_word
    : 32'h0;

  // Write channel: address and data taken in either order
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      else if (b_done)
      begin
        aw_full_reg <= 1'b0;
        awready_reg <= 1'b1;
      end
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      else if (b_done)
      begin
        w_full_reg <= 1'b0;
        wready_reg <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= CPA_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? CPA_RESP_OKAY : CPA_RESP_SLVERR;
    end
    else if (b_done)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel, answer in the cycle after the address is taken
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= CPA_RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else if (ar_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_ok ? CPA_RESP_OKAY : CPA_RESP_SLVERR;
      rdata_reg <= rd_word;
    end
    else if (r_done)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Per-channel registers and compare units
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic sel_wr;
    assign sel_wr = wr_fire && (wr_ch == 2'(i));
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        ctrl_reg[i] <= CPA_CTRL_RESET;
        value_reg[i] <= CPA_VALUE_RESET;
      end
      else
      begin
        if (sel_wr && wr_ctrl && wstrb_reg[0])
          ctrl_reg[i] <= wdata_reg[CPA_CTRL_WIDTH-1:0];
        if (sel_wr && wr_value && wstrb_reg[0])
          value_reg[i][7:0] <= wdata_reg[7:0];
        if (sel_wr && wr_value && wstrb_reg[1])
          value_reg[i][15:8] <= wdata_reg[15:8];
      end
    end

    cpa_channel u_channel (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .compare_select_bit(ctrl_reg[i][CPA_SEL_POS]),
      .clear_on_match_bit(ctrl_reg[i][CPA_CLR_POS]),
      .match_action_field(ctrl_reg[i][CPA_ACT_POS+CPA_ACT_WIDTH-1:CPA_ACT_POS]),
      .value_buf(value_reg[i]),
      .timebase_count(timebase_count),
      .timebase_step(timebase_step),
      .timebase_wrap(timebase_wrap),
      .counting_down(timebase_counting_down),
      .center_mode(count_mode_field[1]),
      .top_active(top_active_reg),
      .match_event(match_evt[i]),
      .clear_request(clear_req[i]),
      .pwm_active(pwm_on[i]),
      .pin_state(pin_state[i])
    );

    // Converter owns C and D; external bus owns all pins
    assign pin_block[i] = config_reg[CPA_EXT_BUS_POS]
      || (config_reg[CPA_CONV_EN_POS] && (i >= 2));
  end

  // Flags: hardware set wins over write-one-to-clear
  logic [NCH-1:0] flag_clr;
  assign flag_clr = (wr_fire && wr_flag && wstrb_reg[0]) ? wdata_reg[NCH-1:0] : '0;
  assign flag_next = (flag_reg & ~flag_clr) | match_evt;

  // Flags, config, TOP buffer, timebase clear and pins
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_reg <= '0;
      config_reg <= 2'h0;
      top_active_reg <= CPA_TOP_RESET;
      timebase_clear_reg <= 1'b0;
      pin_out_reg <= {NCH{CPA_PIN_RESET}};
      pin_en_reg <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
      if (wr_fire && wr_config && wstrb_reg[0])
        config_reg <= wdata_reg[1:0];
      if (timebase_wrap)
        top_active_reg <= top_value;
      timebase_clear_reg <= |clear_req;
      pin_out_reg <= pin_state;
      pin_en_reg <= ~pin_block;
    end
  end

  // Outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign timebase_clear = timebase_clear_reg;
  assign channel_output_pin = pin_out_reg;
  assign channel_output_enable = pin_en_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Checks on the array
  match_event_a: assert property (ctrl_reg[0][CPA_SEL_POS] && timebase_step
    && timebase_count == value_reg[0] && !pwm_on[0] && $stable(value_reg[0])
    |-> match_evt[0])
    else $error("equal count did not raise a compare event");
  flag_set_a: assert property (match_evt[0] |=> flag_reg[0])
    else $error("compare event did not set the flag");
  timebase_clear_a: assert property (|clear_req |=> timebase_clear ##1 !timebase_clear
    or ##1 timebase_clear ##1 $past(|clear_req))
    else $error("clear-on-match did not pulse the timebase clear");
  pin_block_a: assert property (config_reg[CPA_EXT_BUS_POS] |=>
    channel_output_enable == '0)
    else $error("pin driven while the external bus owns the port");
  conv_block_a: assert property (config_reg[CPA_CONV_EN_POS] |=>
    !channel_output_enable[2] && !channel_output_enable[3])
    else $error("channel C or D driven while the converter is on");
  top_update_a: assert property (!timebase_wrap |=> $stable(top_active_reg))
    else $error("TOP changed away from the wrap");
  clr_pulse_a: assert property (!(|clear_req) |=> !timebase_clear)
    else $error("timebase cleared without a match");
  pin_follow_a: assert property (##1 1'b1 |-> channel_output_pin == $past(pin_state, 1))
    else $error("pin output does not follow channel state");

  match_cover_c: cover property (match_evt[0] ##1 flag_reg[0]);
  clear_cover_c: cover property (clear_req[1] ##1 timebase_clear);
  write_cover_c: cover property (wr_fire && wr_value ##1 s_axi_bvalid);
endmodule
`default_nettype wire

// File: verification/cpa_tb_timebase.sv
// Behavioural timebase counter that feeds the channel array
`default_nettype none
module cpa_tb_timebase
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bench setup
  input wire logic run,
  input wire logic center,
  input wire logic [3:0] presc,
  input wire logic [15:0] top,
  input wire logic clear,
  // Counter view
  output logic [15:0] count,
  output logic step,
  output logic wrap,
  output logic down
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_reg;
  logic [15:0] top_reg;
  // Prescaled counter; TOP is only taken at a restart, so a period never tears
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= 16'h0000;
      step <= 1'b0;
      wrap <= 1'b0;
      down <= 1'b0;
      div_reg <= 4'h0;
      top_reg <= 16'hffff;
    end
    else
    begin
      step <= 1'b0;
      wrap <= 1'b0;
      div_reg <= div_reg + 4'h1;
      if (!run)
      begin
        top_reg <= top;
        count <= 16'h0000;
      end
      else if (clear)
      begin
        count <= 16'h0000;
        down <= 1'b0;
        div_reg <= 4'h0;
        step <= 1'b1;
      end
      else if (div_reg >= presc)
      begin
        div_reg <= 4'h0;
        step <= 1'b1;
        if ((down && count == 16'h0001) || (!center && count >= top_reg))
        begin
          count <= 16'h0000;
          wrap <= 1'b1;
          down <= 1'b0;
          top_reg <= top;
        end
        else if (center && (down || count >= top_reg))
        begin
          down <= 1'b1;
          count <= count - 16'h0001;
        end
        else
          count <= count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/cpa_top_tb.sv
// Self-checking bench for the compare and PWM channel array
`default_nettype none
module cpa_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpa_pkg::*;
  typedef struct packed {logic [1:0] ch; logic [2:0] act; logic [15:0] val;
    logic pin;} cpa_row_type;
  logic sys_clk, tb_clear, awready, wready, bvalid, arready, rvalid, step, wrap, down;
  logic reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, run = 1'b0, center = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf, presc = 4'h1, pin, oe;
  logic [1:0] cm = 2'h1, bresp, rresp, r;
  logic [15:0] top = 16'h0020, count;
  int err_total = 0, n_tests = 0, cyc = 0, nclr = 0, hi [4], tg [4], ex [4];
  // Compare rows: channel, action, value, pin level after the match
  cpa_row_type rows [9] = '{'{2'd0, 3'h2, 16'h0003, 1'b0}, '{2'd0, 3'h3, 16'h0020, 1'b1},
    '{2'd0, 3'h0, 16'h0005, 1'b1}, '{2'd1, 3'h3, 16'h0010, 1'b0}, '{2'd1, 3'h1, 16'h0007, 1'b1},
    '{2'd2, 3'h7, 16'h0001, 1'b1}, '{2'd2, 3'h2, 16'h0000, 1'b0}, '{2'd3, 3'h6, 16'h001f, 1'b1},
    '{2'd3, 3'h3, 16'h0009, 1'b0}};
  cpa_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timebase_count(count), .timebase_step(step), .timebase_wrap(wrap),
    .timebase_counting_down(down), .top_value(top), .count_mode_field(cm),
    .timebase_clear(tb_clear), .channel_output_pin(pin), .channel_output_enable(oe));
  cpa_tb_timebase tbm (.sys_clk(sys_clk), .reset_n(reset_n), .run(run), .center(center),
    .presc(presc), .top(top), .clear(tb_clear), .count(count), .step(step), .wrap(wrap),
    .down(down));
  // Clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axw(a, v, r);
    chk("bresp", 32'(CPA_RESP_OKAY), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    axr(a, d, r);
    chk(nm, e, d);
    chk("rresp", 32'(CPA_RESP_OKAY), 32'(r));
  endtask
  function automatic logic [31:0] ctl(input logic clr, input logic [2:0] act);
    return (32'(act) << CPA_ACT_POS) | (32'(clr) << CPA_CLR_POS) | (32'h1 << CPA_SEL_POS);
  endfunction
  // Waits for a counter step showing the value, this edge included, then lets the pin settle
  task automatic wait_match(input logic [15:0] v);
    for (int k = 0; k < 400; k++)
    begin
      if (step === 1'b1 && count === v) break;
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Counts high cycles and level changes of every pin
  task automatic measure(input int n);
    logic [3:0] p;
    p = pin;
    hi = '{0, 0, 0, 0};
    tg = '{0, 0, 0, 0};
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 4; i++) hi[i] += int'(pin[i] === 1'b1);
      for (int i = 0; i < 4; i++) tg[i] += int'(pin[i] !== p[i]);
      p = pin;
    end
    for (int i = 0; i < 4; i++) chk("pwm high cycles", 32'(ex[i]), 32'(hi[i]));
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    chk("reset pins", 32'hf, 32'(pin));
    chk("reset enables", 32'h0, 32'(oe));
    @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    run <= 1'b1;
    #1;
    chk("enables", 32'hf, 32'(oe));
    rd(CPA_CTRL_BASE_OFS, 32'h0, "ctrl reset");
    rd(CPA_VALUE_BASE_OFS + 8'h4, 32'h0, "value reset");
    axw(8'h3c, 32'h1, r);
    chk("unmapped bresp", 32'(CPA_RESP_SLVERR), 32'(r));
    axr(8'h3c, d, r);
    chk("unmapped rresp", 32'(CPA_RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    // Table of compare actions, one match each, prescaler holding values two cycles
    foreach (rows[i])
    begin
      wr(CPA_VALUE_BASE_OFS + 8'(4 * rows[i].ch), 32'(rows[i].val));
      wr(CPA_CTRL_BASE_OFS + 8'(4 * rows[i].ch), ctl(1'b0, rows[i].act));
      wait_match(rows[i].val);
      chk("pin", 32'(rows[i].pin), 32'(pin[rows[i].ch]));
      rd(CPA_FLAG_OFS, 32'h1 << rows[i].ch, "flags");
      wr(CPA_CTRL_BASE_OFS + 8'(4 * rows[i].ch), 32'h0);
      wr(CPA_FLAG_OFS, 32'h1 << rows[i].ch);
    end
    // Converter and external bus take the pins; flags keep working
    wr(CPA_CONFIG_OFS, 32'h1);
    wr(CPA_VALUE_BASE_OFS + 8'hc, 32'h5);
    wr(CPA_CTRL_BASE_OFS + 8'hc, ctl(1'b0, CPA_ACT_SET));
    wait_match(16'h0005);
    chk("enables converter", 32'h3, 32'(oe));
    rd(CPA_FLAG_OFS, 32'h8, "flags blocked");
    rd(CPA_STATUS_OFS, 32'h0b, "status pins");
    wr(CPA_CONFIG_OFS, 32'h2);
    #1;
    chk("enables bus", 32'h0, 32'(oe));
    wr(CPA_CONFIG_OFS, 32'h0);
    #1;
    chk("enables back", 32'hf, 32'(oe));
    chk("pins back", 32'hb, 32'(pin));
    wr(CPA_CTRL_BASE_OFS + 8'hc, 32'h0);
    // Clear on match keeps the counter short
    wr(CPA_VALUE_BASE_OFS + 8'h4, 32'h5);
    wr(CPA_CTRL_BASE_OFS + 8'h4, ctl(1'b1, CPA_ACT_TOGGLE));
    repeat (40) @(posedge sys_clk);
    nclr = 0;
    ex[0] = 0;
    repeat (120)
    begin
      @(posedge sys_clk);
      if (count > 16'(ex[0])) ex[0] = int'(count);
      if (tb_clear === 1'b1) nclr++;
    end
    chk("ctc top count", 32'h1, 32'(ex[0] <= 6));
    chk("ctc clears", 32'h1, 32'(nclr >= 4));
    wr(CPA_CTRL_BASE_OFS + 8'h4, 32'h0);
    // Edge-aligned PWM, both polarities and both extremes
    presc <= 4'h0;
    top <= 16'h000f;
    for (int i = 0; i < 4; i++)
      wr(CPA_VALUE_BASE_OFS + 8'(4 * i), i == 3 ? 32'hf : i < 2 ? 32'h4 : 32'h0);
    for (int i = 0; i < 4; i++)
      wr(CPA_CTRL_BASE_OFS + 8'(4 * i), ctl(1'b0, i == 1 ? 3'h4 : 3'h5));
    repeat (64) @(posedge sys_clk);
    ex = '{48, 16, 64, 0};
    measure(64);
    axr(CPA_STATUS_OFS, d, r);
    chk("pwm active", 32'hf, 32'(d[7:4]));
    top <= 16'h001f;
    repeat (96) @(posedge sys_clk);
    ex = '{56, 8, 64, 34};
    measure(64);
    // Dual slope: mid-value toggle acts on both slopes; PWM channels stay centred
    cm <= 2'h2;
    center <= 1'b1;
    top <= 16'h0008;
    wr(CPA_VALUE_BASE_OFS + 8'hc, 32'h2);
    wr(CPA_VALUE_BASE_OFS, 32'h4);
    wr(CPA_CTRL_BASE_OFS, ctl(1'b0, CPA_ACT_TOGGLE));
    repeat (80) @(posedge sys_clk);
    ex = '{16, 16, 32, 8};
    measure(32);
    chk("dual slope toggles", 32'h4, 32'(tg[0]));
    finish_test();
  end
endmodule
`default_nettype wire
